// *** flash_sector_erase_program_read.sv ***
// Flash sequencer: key lock, sector erase, byte program and byte read.
// Assumes the core keeps its own sequencing and dummy-cycle duties.
//
// Function
// - Partial erase only in user mode; sector is the erase/program unit.
// - Flash is 128 sectors of 128 bytes each.
// - Sector erase lasts at least 10 ms after the start bit.
// - No sector erase while a tool program mode is active.
// - Control bit 3 reports erase outcome; core retries on failure.
// - Flash is programmed one byte at a time.
// - Each store writes one byte; up to 128 per sector.
// - Load returns flash byte at the 16-bit pointer address.
// - Key resets to zero; any value except a5h means locked.
// - Interrupt aborts erase; status 1 on failure, 0 on success.
// - Start bit triggers erase only; reads and programs ignore it.
// - Low seven bits of sector low register are ignored.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_sector_erase_program_read #(
  parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES
) (
  input  wire logic                                 CLK,
  input  wire logic                                 RST_B,
  input  wire logic [flash_seq_pkg::REG_ADDR_W-1:0] ADDR,
  input  wire logic [flash_seq_pkg::DATA_W-1:0]     WDATA,
  input  wire logic                                 WR,
  input  wire logic                                 RD,
  output logic      [flash_seq_pkg::DATA_W-1:0]     RDATA,
  input  wire logic [flash_seq_pkg::PM_ADDR_W-1:0]  PM_ADDR,
  input  wire logic [flash_seq_pkg::DATA_W-1:0]     PM_WDATA,
  input  wire logic                                 PM_WR,
  input  wire logic                                 PM_RD,
  output logic      [flash_seq_pkg::DATA_W-1:0]     PM_RDATA,
  input  wire logic                                 IRQ,
  input  wire logic                                 TOOL_MODE,
  output logic                                      BUSY
);
  import flash_seq_pkg::*;

  localparam int AW = $clog2(SECTORS * SECTOR_BYTES);
  localparam int SW = $clog2(SECTORS);
  localparam int CW = $clog2(ERASE_CYCLES + 1);

  seq_state_type  state_r;
  logic [3:0]     mode_r;
  logic           start_r;
  logic           status_r;
  logic [7:0]     key_r;
  logic [7:0]     sech_r;
  logic           secl_r;
  logic [SW-1:0]  erase_sec_r;
  logic [CW-1:0]  cnt_r;
  logic [2:0]     tool_sync_r;
  logic           tool_r;
  logic           unlocked;
  logic           erase_req;
  logic           erase_done;
  logic           in_sector;
  logic           flash_we;
  logic [7:0]     array_rdata;
  logic [7:0]     rd_byte;
  logic [7:0]     reg_rd_nxt;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : is_reg

  assign unlocked = (key_r == KEY_UNLOCK);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tool_sync_r <= 3'h0;
      tool_r      <= 1'b0;
    end else begin
      tool_sync_r <= {tool_sync_r[1:0], TOOL_MODE};
      if (tool_sync_r[1] == tool_sync_r[2]) begin
        tool_r <= tool_sync_r[2];
      end
    end
  end

  // Erase start needs key, erase mode and start bit
  assign erase_req = WR && is_reg(ADDR, OFS_CTRL) && unlocked && !tool_r
                     && (WDATA[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_ERASE)
                     && WDATA[CTRL_START] && (state_r == IDLE);
  assign erase_done = (state_r == ERASING) && !IRQ
                      && (cnt_r == CW'(ERASE_CYCLES - 1));

  // Sector base from high byte and bit 7 of low byte only
  assign in_sector = (PM_ADDR[15:7] == {sech_r, secl_r});
  // Programming does not look at the start bit
  // One byte per store, loaded sector only
  assign flash_we = PM_WR && unlocked && !tool_r && (mode_r == MODE_PROG)
                    && in_sector && (state_r == IDLE);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_r     <= IDLE;
      cnt_r       <= '0;
      erase_sec_r <= '0;
    end else begin
      unique case (state_r)
        IDLE: begin
          cnt_r <= '0;
          if (erase_req) begin
            state_r     <= ERASING;
            erase_sec_r <= {sech_r[SW-2:0], secl_r};
          end
        end
        ERASING: begin
          cnt_r <= cnt_r + CW'(1);
          if (IRQ || erase_done) begin
            state_r <= IDLE;
          end
        end
      endcase
    end
  end

  // Control register; mode frozen while erasing
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mode_r  <= 4'h0;
      start_r <= 1'b0;
    end else if (state_r == ERASING) begin
      if (IRQ || erase_done) begin
        start_r <= 1'b0;
      end
    end else if (WR && is_reg(ADDR, OFS_CTRL)) begin
      mode_r  <= WDATA[CTRL_MODE_HI:CTRL_MODE_LO];
      start_r <= erase_req;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      status_r <= 1'b0;
    end else if (state_r == ERASING && IRQ) begin
      status_r <= 1'b1;
    end else if (erase_done) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      key_r  <= KEY_RESET;
      sech_r <= 8'h00;
      secl_r <= 1'b0;
    end else if (WR) begin
      if (is_reg(ADDR, OFS_KEY)) begin
        key_r <= WDATA;
      end
      if (is_reg(ADDR, OFS_SECH)) begin
        sech_r <= WDATA;
      end
      if (is_reg(ADDR, OFS_SECL)) begin
        secl_r <= WDATA[7];
      end
    end
  end

  always_comb begin
    reg_rd_nxt = 8'h00;
    if (is_reg(ADDR, OFS_CTRL)) begin
      reg_rd_nxt = {mode_r, status_r, 2'h0, start_r};
    end else if (is_reg(ADDR, OFS_KEY)) begin
      reg_rd_nxt = key_r;
    end else if (is_reg(ADDR, OFS_SECH)) begin
      reg_rd_nxt = sech_r;
    end else if (is_reg(ADDR, OFS_SECL)) begin
      reg_rd_nxt = {secl_r, 7'h00};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? reg_rd_nxt : 8'h00;
    end
  end

  assign rd_byte = (PM_ADDR[15:AW] == '0) ? array_rdata : ERASED_BYTE;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PM_RDATA <= 8'h00;
      BUSY     <= 1'b0;
    end else begin
      PM_RDATA <= PM_RD ? rd_byte : 8'h00;
      BUSY     <= (state_r == ERASING) ? !(IRQ || erase_done) : erase_req;
    end
  end

  flash_array #(
    .SECTORS      (SECTORS),
    .SECTOR_BYTES (SECTOR_BYTES)
  ) u_array (
    .clk          (CLK),
    .we           (flash_we),
    .waddr        (PM_ADDR[AW-1:0]),
    .wdata        (PM_WDATA),
    .erase        (erase_done),
    .erase_sector (erase_sec_r),
    .raddr        (PM_ADDR[AW-1:0]),
    .rdata        (array_rdata)
  );

  sequence seq_erase_start;
    erase_req;
  endsequence

  sequence seq_abort;
    state_r == ERASING && IRQ;
  endsequence

  a_erase_length: assert property (
    @(posedge CLK) disable iff (!RST_B)
    erase_done |-> cnt_r == CW'(ERASE_CYCLES - 1) && start_r)
    else $error("erase finished before its full count");

  a_erase_begins: assert property (
    @(posedge CLK) disable iff (!RST_B)
    seq_erase_start |=> state_r == ERASING && BUSY && start_r)
    else $error("erase start not taken");

  a_abort_fails: assert property (
    @(posedge CLK) disable iff (!RST_B)
    seq_abort |=> state_r == IDLE && status_r && !BUSY)
    else $error("interrupted erase not flagged as failure");

  a_success_clears: assert property (
    @(posedge CLK) disable iff (!RST_B)
    erase_done |=> !status_r && !start_r && state_r == IDLE)
    else $error("successful erase left failure flag");

  a_tool_blocks: assert property (
    @(posedge CLK) disable iff (!RST_B)
    tool_r && state_r == IDLE |=> state_r == IDLE)
    else $error("erase began in tool mode");

  a_locked_quiet: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (flash_we || erase_req) |-> key_r == KEY_UNLOCK)
    else $error("flash changed while locked");

  a_sector_guard: assert property (
    @(posedge CLK) disable iff (!RST_B)
    flash_we |-> PM_ADDR[15:7] == {sech_r, secl_r})
    else $error("store outside loaded sector accepted");

  a_store_no_start: assert property (
    @(posedge CLK) disable iff (!RST_B)
    PM_WR && unlocked && !tool_r && mode_r == MODE_PROG && in_sector
    && state_r == IDLE && !start_r |-> flash_we)
    else $error("programming waited on start bit");

  a_load_data: assert property (
    @(posedge CLK) disable iff (!RST_B)
    PM_RD |=> PM_RDATA == $past(rd_byte))
    else $error("load returned wrong byte");

  a_key_value: assert property (
    @(posedge CLK) disable iff (!RST_B)
    WR && is_reg(ADDR, OFS_KEY) && WDATA != KEY_UNLOCK |=> !unlocked)
    else $error("wrong key unlocked programming");
endmodule : flash_sector_erase_program_read
`default_nettype wire

// *** flash_seq_pkg.sv ***
// Constants shared by the flash sequencer and its storage array.
// Assumes a 10 MHz system clock and a byte-wide register port.
package flash_seq_pkg;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          ERASE_TIME_MS  = 10;
  localparam int          ERASE_CYCLES   = (ERASE_TIME_MS * CLK_HZ + 999) / 1000;
  localparam int          SECTORS        = 128;
  localparam int          SECTOR_BYTES   = 128;
  localparam int          REG_ADDR_W     = 8;
  localparam int          DATA_W         = 8;
  localparam int          PM_ADDR_W      = 16;
  localparam int          OFF_W          = 7;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_KEY        = 8'h01;
  localparam logic [7:0]  OFS_SECH       = 8'h02;
  localparam logic [7:0]  OFS_SECL       = 8'h03;
  localparam int          CTRL_MODE_HI   = 7;
  localparam int          CTRL_MODE_LO   = 4;
  localparam int          CTRL_STATUS    = 3;
  localparam int          CTRL_START     = 0;
  localparam logic [3:0]  MODE_ERASE     = 4'ha;
  localparam logic [3:0]  MODE_PROG      = 4'h5;
  localparam logic [7:0]  KEY_UNLOCK     = 8'ha5;
  localparam logic [7:0]  KEY_RESET      = 8'h00;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  typedef enum logic [0:0] {IDLE, ERASING} seq_state_type;
endpackage : flash_seq_pkg

// *** flash_array.sv ***
// Flip-flop model of the program flash, sector-erasable.
// Assumes one write or one erase per cycle from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_array #(
  parameter int SECTORS      = 128,
  parameter int SECTOR_BYTES = 128
) (
  input  wire logic                                      clk,
  input  wire logic                                      we,
  input  wire logic [$clog2(SECTORS*SECTOR_BYTES)-1:0]   waddr,
  input  wire logic [7:0]                                wdata,
  input  wire logic                                      erase,
  input  wire logic [$clog2(SECTORS)-1:0]                erase_sector,
  input  wire logic [$clog2(SECTORS*SECTOR_BYTES)-1:0]   raddr,
  output logic      [7:0]                                rdata
);
  localparam int OW = $clog2(SECTOR_BYTES);
  localparam int AW = $clog2(SECTORS*SECTOR_BYTES);

  logic [7:0] mem [SECTORS*SECTOR_BYTES];

  // Contents are not reset: flash keeps data over a reset
  always_ff @(posedge clk) begin
    if (erase) begin
      for (int i = 0; i < SECTOR_BYTES; i++) begin
        mem[{erase_sector, OW'(i)}] <= 8'hff;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : flash_array
`default_nettype wire

// *** dummy_end_marker_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** cpu_core_model.sv ***
// Core-side model: register port cycles and program-memory load/store.
// Assumes one shared clock; all strobes change just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic [7:0]  rdata,
  input  wire logic [7:0]  pm_rdata,
  input  wire logic        clk,
  output var  logic [7:0]  addr,
  output var  logic [7:0]  wdata,
  output var  logic        wr,
  output var  logic        rd,
  output var  logic [15:0] pm_addr,
  output var  logic [7:0]  pm_wdata,
  output var  logic        pm_wr,
  output var  logic        pm_rd,
  output var  logic        irq
);
  import flash_seq_pkg::*;
  initial begin
    {addr, wdata, wr, rd, pm_addr, pm_wdata, pm_wr, pm_rd, irq} = '0;
  end
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    // Released data shows the inverse, never a stale copy
    wdata <= ~d;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    // Answer stands only until the next edge, so take it now
    #1;
    d = rdata;
  endtask : reg_rd
  task pm_store(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    pm_addr  <= a;
    pm_wdata <= d;
    pm_wr    <= 1'b1;
    @(posedge clk);
    pm_wr    <= 1'b0;
    pm_wdata <= ~d;
  endtask : pm_store
  task pm_load(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    pm_addr <= a;
    pm_rd   <= 1'b1;
    @(posedge clk);
    pm_rd   <= 1'b0;
    #1;
    d = pm_rdata;
  endtask : pm_load
  task nop(input int n);
    repeat (n) @(posedge clk);
  endtask : nop
  task irq_set(input logic v);
    @(posedge clk);
    irq <= v;
  endtask : irq_set
  task erase(input logic [15:0] s);
    reg_wr(OFS_KEY, KEY_UNLOCK);
    reg_wr(OFS_SECH, s[15:8]);
    reg_wr(OFS_SECL, s[7:0]);
    reg_wr(OFS_CTRL, 8'ha1);
  endtask : erase
  task prog(input logic [15:0] a, input logic [7:0] d, input logic [15:0] s);
    reg_wr(OFS_KEY, KEY_UNLOCK);
    reg_wr(OFS_SECH, s[15:8]);
    reg_wr(OFS_SECL, s[7:0]);
    reg_wr(OFS_CTRL, 8'h51);
    pm_store(a, d);
    nop(1);
    reg_wr(OFS_KEY, KEY_RESET);
  endtask : prog
endmodule : cpu_core_model
`default_nettype wire

// *** flash_sector_erase_program_read_tb_top.sv ***
// Self-checking bench for the flash sequencer, driven through a core model.
// Assumes a shortened erase count so one sector erase lasts 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module flash_sector_erase_program_read_tb_top;
  import flash_seq_pkg::*;
  localparam int ERC = 20;
  int          seed = 57503;
  int          fails = 0;
  int          checked = 0;
  int          n;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        tool = 1'b0;
  logic        wr, rd, pm_wr, pm_rd, irq, busy;
  logic [7:0]  addr, wdata, rdata, pm_wdata, pm_rdata, d, g;
  logic [15:0] pm_addr, base, other;
  logic [6:0]  ofs [8];
  logic [7:0]  val [8];
  always #50 clk = ~clk;
  cpu_core_model i_cpu_core_model (.clk(clk), .rdata(rdata),
    .pm_rdata(pm_rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_wr(pm_wr), .pm_rd(pm_rd),
    .irq(irq));
  flash_sector_erase_program_read #(.ERASE_CYCLES(ERC))
    i_flash_sector_erase_program_read (.CLK(clk), .RST_B(rst_b),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PM_ADDR(pm_addr), .PM_WDATA(pm_wdata), .PM_WR(pm_wr), .PM_RD(pm_rd),
    .PM_RDATA(pm_rdata), .IRQ(irq), .TOOL_MODE(tool), .BUSY(busy));
  function automatic logic [15:0] sector_base(input logic [6:0] s);
    return {2'b00, s, 7'h00};
  endfunction : sector_base
  function automatic logic [7:0] ctrl_view(input logic failed);
    return {MODE_ERASE, failed, 3'b000};
  endfunction : ctrl_view
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task wait_busy(output int c);
    c = 0;
    // Let the launching edge settle before looking at busy
    #1;
    while (busy === 1'b1 && c < 4 * ERC) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (busy !== 1'b0) begin
      fails++;
      conclude();
    end
  endtask : wait_busy
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 5; a++) begin
      i_cpu_core_model.reg_rd(8'(a), g);
      chk(g, 8'h00);
    end
    d = 8'($random(seed));
    i_cpu_core_model.reg_wr(OFS_SECL, d);
    i_cpu_core_model.reg_rd(OFS_SECL, g);
    chk(g, {d[7], 7'h00});
    // Bit 0 clear keeps the key away from the unlock value
    i_cpu_core_model.reg_wr(OFS_KEY, d & 8'hfe);
    i_cpu_core_model.reg_wr(OFS_CTRL, 8'ha1);
    #1;
    chk({7'h00, busy}, 8'h00);
    @(posedge clk);
    tool <= 1'b1;
    i_cpu_core_model.nop(4);
    i_cpu_core_model.erase(sector_base(7'h05));
    #1;
    chk({7'h00, busy}, 8'h00);
    @(posedge clk);
    tool <= 1'b0;
    i_cpu_core_model.nop(4);
    $display("lock and tool mode test done");
    base = sector_base(7'($random(seed)));
    other = base ^ 16'h0080;
    i_cpu_core_model.erase(base);
    #1;
    chk({7'h00, busy}, 8'h01);
    // the busy wait covers the dummy cycles
    wait_busy(n);
    chk(8'(n), 8'(ERC));
    i_cpu_core_model.reg_wr(OFS_KEY, KEY_RESET);
    i_cpu_core_model.reg_rd(OFS_CTRL, g);
    chk(g, ctrl_view(1'b0));
    for (int k = 0; k < 6; k++) begin
      i_cpu_core_model.pm_load(base | 16'((k * 127) / 5), g);
      chk(g, ERASED_BYTE);
    end
    $display("erase test done");
    for (int k = 0; k < 8; k++) begin
      ofs[k] = {k[2:0], 4'($random(seed))};
      if (k == 7) ofs[k] = 7'h7f;
      if (k == 0) ofs[k] = 7'h00;
      val[k] = 8'($random(seed));
      i_cpu_core_model.prog(base | 16'(ofs[k]), val[k], base);
    end
    for (int k = 0; k < 8; k++) begin
      i_cpu_core_model.pm_load(base | 16'(ofs[k]), g);
      chk(g, val[k]);
    end
    i_cpu_core_model.prog(base, ~val[0], other);
    i_cpu_core_model.pm_load(base, g);
    chk(g, val[0]);
    // Matching sector, so only the lock can refuse the store
    i_cpu_core_model.reg_wr(OFS_SECH, base[15:8]);
    i_cpu_core_model.reg_wr(OFS_SECL, base[7:0]);
    i_cpu_core_model.pm_store(base, ~val[0]);
    i_cpu_core_model.pm_load(base, g);
    chk(g, val[0]);
    $display("program and read test done");
    i_cpu_core_model.erase(other);
    i_cpu_core_model.nop(3);
    i_cpu_core_model.irq_set(1'b1);
    i_cpu_core_model.irq_set(1'b0);
    wait_busy(n);
    chk(8'(n), 8'h00);
    i_cpu_core_model.reg_rd(OFS_CTRL, g);
    chk(g, ctrl_view(1'b1));
    i_cpu_core_model.erase(other);
    wait_busy(n);
    chk(8'(n), 8'(ERC));
    i_cpu_core_model.reg_wr(OFS_KEY, KEY_RESET);
    i_cpu_core_model.reg_rd(OFS_CTRL, g);
    chk(g, ctrl_view(1'b0));
    $display("abort and retry test done");
    conclude();
  end
endmodule : flash_sector_erase_program_read_tb_top
`default_nettype wire
